// file: dac_serial_consts.svh
// Notes on behaviour
// - while frame select is low, data is sampled on each of the first sixteen falling shift clocks.
// - sixteenth falling edge loads twelve data bits and two mode bits.
// - frame is two ignored bits, two mode bits, twelve data bits.
// - frame select rising before edge sixteen clears shift register, nothing updates.
// - power-up clears the converter register to zero until a valid write.
// - mode 00 normal, 01 1k pull, 10 100k pull, 11 three-state.
// - power-down switches output from amplifier to the selected termination.
// - power-down disables bias, amplifier, string; converter value kept.
`ifndef DAC_SERIAL_CONSTS_SVH
`define DAC_SERIAL_CONSTS_SVH
`define FRAME_BITS 16
`define DATA_BITS 12
`define DATA_LSB 0
`define MODE_LSB 12
`define COUNT_LAST 5'h10
`define DATA_RESET 12'h000
`define MODE_RESET 2'h0
`define ANALOG_RESET 6'h27
`define FRAME_RESET 16'h0000
`endif

// file: dac_serial_pkg.sv
package dac_serial_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_PD_1K = 2'h1,
        MODE_PD_100K = 2'h2,
        MODE_PD_OPEN = 2'h3
    } op_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SHIFT = 3'h2,
        ST_DONE = 3'h4
    } frame_state_e;

    typedef struct packed {
        logic amp_select;
        logic pull_1k;
        logic pull_100k;
        logic bias_enable;
        logic amp_enable;
        logic string_enable;
    } analog_ctl_s;

    typedef struct packed {
        logic [2:0] sel_sync;
        logic [2:0] clk_sync;
        logic [2:0] din_sync;
        frame_state_e state;
        logic [4:0] count;
        logic [15:0] input_frame_shift;
        logic [11:0] dac_code;
        op_mode_e mode;
        analog_ctl_s analog;
        logic load_pulse;
    } dac_state_s;
endpackage : dac_serial_pkg

// file: dac_serial_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_serial_consts.svh"

module dac_serial_ctrl (
    input wire logic MCLK_IN,
    input wire logic RSTN_IN,
    input wire logic FRAME_SEL_N_IN,
    input wire logic SHIFT_CLK_IN,
    input wire logic SER_DATA_IN,
    output logic [11:0] DAC_CODE_OUT,
    output dac_serial_pkg::op_mode_e MODE_OUT,
    output dac_serial_pkg::analog_ctl_s ANALOG_CTL_OUT,
    output logic LOAD_OUT
);
    import dac_serial_pkg::*;

    dac_state_s r;
    dac_state_s next_r;
    logic sel_high;
    logic sel_rise;
    logic sel_fall;
    logic clk_fall;
    logic [15:0] shifted;

    // ****************************************
    // pin sampling: a change counts when stages two and three differ
    // ****************************************
    always_comb begin
        sel_high = r.sel_sync[1] & r.sel_sync[2];
        sel_rise = r.sel_sync[1] & ~r.sel_sync[2];
        sel_fall = ~r.sel_sync[1] & r.sel_sync[2];
        clk_fall = ~r.clk_sync[1] & r.clk_sync[2];
        shifted = {r.input_frame_shift[14:0], r.din_sync[1]};
    end

    // ****************************************
    // frame engine
    // ****************************************
    always_comb begin
        next_r = r;
        next_r.sel_sync = {r.sel_sync[1:0], FRAME_SEL_N_IN};
        next_r.clk_sync = {r.clk_sync[1:0], SHIFT_CLK_IN};
        next_r.din_sync = {r.din_sync[1:0], SER_DATA_IN};
        next_r.load_pulse = 1'b0;
        unique case (r.state)
            ST_IDLE: begin
                // only a fresh falling select opens a frame
                if (sel_fall) begin
                    next_r.state = ST_SHIFT;
                    next_r.count = 5'h00;
                    next_r.input_frame_shift = `FRAME_RESET;
                end
            end
            ST_SHIFT: begin
                if (sel_rise || sel_high) begin
                    next_r.state = ST_IDLE;
                    next_r.input_frame_shift = `FRAME_RESET;
                    next_r.count = 5'h00;
                end else if (clk_fall) begin
                    next_r.input_frame_shift = shifted;
                    next_r.count = r.count + 5'h01;
                    if (r.count + 5'h01 == `COUNT_LAST) begin
                        // top two bits are don't-care
                        next_r.dac_code = shifted[`DATA_LSB +: `DATA_BITS];
                        next_r.mode = op_mode_e'(shifted[`MODE_LSB +: 2]);
                        next_r.load_pulse = 1'b1;
                        next_r.state = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                // extra edges are dropped until select goes high
                if (sel_high) begin
                    next_r.state = ST_IDLE;
                end
            end
        endcase
        // output termination follows the applied mode; code is never touched here
        next_r.analog.amp_select = (next_r.mode == MODE_NORMAL);
        next_r.analog.pull_1k = (next_r.mode == MODE_PD_1K);
        next_r.analog.pull_100k = (next_r.mode == MODE_PD_100K);
        next_r.analog.bias_enable = (next_r.mode == MODE_NORMAL);
        next_r.analog.amp_enable = (next_r.mode == MODE_NORMAL);
        next_r.analog.string_enable = (next_r.mode == MODE_NORMAL);
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RSTN_IN) begin
            // select stage resets high so a select held low through reset is seen as a falling select and opens a frame
            r.sel_sync <= 3'h7;
            r.clk_sync <= 3'h0;
            r.din_sync <= 3'h0;
            r.state <= ST_IDLE;
            r.count <= 5'h00;
            r.input_frame_shift <= `FRAME_RESET;
            r.dac_code <= `DATA_RESET;
            r.mode <= MODE_NORMAL;
            r.analog <= analog_ctl_s'(`ANALOG_RESET);
            r.load_pulse <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign DAC_CODE_OUT = r.dac_code;
    assign MODE_OUT = r.mode;
    assign ANALOG_CTL_OUT = r.analog;
    assign LOAD_OUT = r.load_pulse;

    // ****************************************
    // checks
    // ****************************************
    AST_LOAD_ONLY_ON_16: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        LOAD_OUT |-> $past(r.count) == 5'h0f && $past(clk_fall))
        else $error("load without sixteenth edge");
    AST_CODE_STABLE: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        !LOAD_OUT |-> $stable(DAC_CODE_OUT) && $stable(MODE_OUT))
        else $error("code changed without load");
    AST_ABORT_CLEARS: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_SHIFT && sel_rise) |=> r.input_frame_shift == 16'h0000 && r.state == ST_IDLE)
        else $error("abort did not clear");
    AST_SHIFT_IN: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_SHIFT && !sel_rise && !sel_high && clk_fall)
        |=> r.input_frame_shift[0] == $past(r.din_sync[1]))
        else $error("bit not shifted");
    AST_DONE_IGNORES: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_DONE && !sel_high) |=> r.state == ST_DONE && !LOAD_OUT)
        else $error("edge accepted after frame end");
    AST_PD_TERM: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (MODE_OUT != MODE_NORMAL) |-> !ANALOG_CTL_OUT.amp_select
        && ANALOG_CTL_OUT.pull_1k == (MODE_OUT == MODE_PD_1K)
        && ANALOG_CTL_OUT.pull_100k == (MODE_OUT == MODE_PD_100K))
        else $error("wrong termination");
    AST_PD_OFF: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (MODE_OUT != MODE_NORMAL) |-> !ANALOG_CTL_OUT.bias_enable
        && !ANALOG_CTL_OUT.amp_enable && !ANALOG_CTL_OUT.string_enable)
        else $error("power-down left enables on");
    AST_RESET_ZERO: assert property (@(posedge MCLK_IN)
        $rose(RSTN_IN) |-> DAC_CODE_OUT == 12'h000 && MODE_OUT == MODE_NORMAL)
        else $error("reset value wrong");
    AST_LOAD_FIELDS: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        LOAD_OUT |-> DAC_CODE_OUT == r.input_frame_shift[11:0]
        && MODE_OUT == op_mode_e'(r.input_frame_shift[13:12]))
        else $error("fields misplaced");

    // ****************************************
    // checks: frame entry and exit
    // ****************************************
    // a level of select alone must never open a frame
    AST_OPEN_ON_FALL: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_IDLE && sel_fall)
        |=> r.state == ST_SHIFT && r.count == 5'h00 && r.input_frame_shift == `FRAME_RESET)
        else $error("frame not opened on falling select");
    AST_IDLE_WAITS: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_IDLE && !sel_fall) |=> r.state == ST_IDLE && !LOAD_OUT)
        else $error("frame opened without falling select");
    AST_DONE_EXIT: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_DONE && sel_high) |=> r.state == ST_IDLE)
        else $error("frame end not left on high select");
    AST_STATE_LEGAL: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        r.state == ST_IDLE || r.state == ST_SHIFT || r.state == ST_DONE)
        else $error("illegal frame state");

    // ****************************************
    // checks: shifting and counting
    // ****************************************
    // an edge seen together with a rising select is dropped, the abort wins
    AST_COUNT_STEP: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_SHIFT && !sel_rise && !sel_high && clk_fall && r.count != 5'h0f)
        |=> r.state == ST_SHIFT && r.count == $past(r.count) + 5'h01)
        else $error("edge count did not advance");
    AST_COUNT_HOLD: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_SHIFT && !sel_rise && !sel_high && !clk_fall)
        |=> $stable(r.count) && $stable(r.input_frame_shift))
        else $error("shift register moved without an edge");
    AST_SHIFT_ORDER: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_SHIFT && !sel_rise && !sel_high && clk_fall)
        |=> r.input_frame_shift[15:1] == $past(r.input_frame_shift[14:0]))
        else $error("shift register did not move up");
    AST_COUNT_RANGE: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        r.state == ST_SHIFT |-> r.count < `COUNT_LAST)
        else $error("edge count past frame length");

    // ****************************************
    // checks: load and abort
    // ****************************************
    // the last bit goes straight from the pin stage into the code, not via the register
    AST_SIXTEENTH_LOADS: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_SHIFT && !sel_rise && !sel_high && clk_fall && r.count == 5'h0f)
        |=> LOAD_OUT && r.state == ST_DONE)
        else $error("sixteenth edge did not load");
    AST_LAST_BIT: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        LOAD_OUT |-> DAC_CODE_OUT == {$past(r.input_frame_shift[10:0]), $past(r.din_sync[1])})
        else $error("code not taken from frame tail");
    AST_LAST_MODE: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        LOAD_OUT |-> MODE_OUT == op_mode_e'($past(r.input_frame_shift[12:11])))
        else $error("mode not taken from frame");
    AST_LOAD_ONE_CYCLE: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        LOAD_OUT |=> !LOAD_OUT)
        else $error("load pulse too long");
    AST_ABORT_KEEPS: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (r.state == ST_SHIFT && (sel_rise || sel_high))
        |=> !LOAD_OUT && $stable(DAC_CODE_OUT) && $stable(MODE_OUT))
        else $error("aborted frame changed outputs");

    // ****************************************
    // checks: output controls
    // ****************************************
    // power-down gates the analog enables and switches the termination; the code register is left alone
    AST_NORMAL_ON: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (MODE_OUT == MODE_NORMAL) |-> ANALOG_CTL_OUT.amp_select && ANALOG_CTL_OUT.bias_enable
        && ANALOG_CTL_OUT.amp_enable && ANALOG_CTL_OUT.string_enable)
        else $error("normal mode left a block off");
    AST_OPEN_OUT: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (MODE_OUT == MODE_PD_OPEN) |-> !ANALOG_CTL_OUT.amp_select && !ANALOG_CTL_OUT.pull_1k
        && !ANALOG_CTL_OUT.pull_100k)
        else $error("open output still terminated");
    AST_PD_KEEPS_CODE: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
        (MODE_OUT != MODE_NORMAL && !LOAD_OUT) |-> $stable(DAC_CODE_OUT))
        else $error("code lost in power-down");
    AST_RESET_CONTROLS: assert property (@(posedge MCLK_IN)
        $rose(RSTN_IN) |-> ANALOG_CTL_OUT == analog_ctl_s'(`ANALOG_RESET) && !LOAD_OUT)
        else $error("reset controls wrong");
endmodule : dac_serial_ctrl
`default_nettype wire

// file: dac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
    input wire logic clk_in,
    output logic sel_n_out,
    output logic sclk_out,
    output logic din_out
);
    // shift clock idles low and only runs inside a frame
    initial begin
        sel_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out = 1'b0;
    end
    task automatic send(input logic [15:0] word, input int n, input bit split, input bit park);
        @(posedge clk_in);
        #1;
        sel_n_out = 1'b1;
        // quarter-ns offset keeps every link edge off a system clock edge
        #40.25;
        sel_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            din_out = word[15 - (i % 16)];
            sclk_out = 1'b1;
            #62.5;
            sclk_out = 1'b0;
            #62.5;
            if (split && i == 7) #300;
        end
        // released data line must not keep the last bit
        din_out = ~din_out;
        sel_n_out = ~park;
    endtask : send
endmodule : dac_host_model
`default_nettype wire

// file: serial_dac_write_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_dac_write_control_tb;
    import dac_serial_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    wire logic sel_n, sclk, din;
    logic [11:0] code;
    op_mode_e mode;
    analog_ctl_s actl;
    logic load;
    int fail_count = 0;
    int n_compared = 0;
    int n_load = 0;
    int exp_load = 0;
    logic [31:0] seed = 32'h569a557f;
    logic [11:0] exp_code = 12'h000;
    logic [1:0] exp_mode = 2'h0;
    always #2 mclk = ~mclk;
    always @(posedge mclk) if (load === 1'b1) n_load++;
    dac_host_model host (.clk_in(mclk), .sel_n_out(sel_n), .sclk_out(sclk), .din_out(din));
    dac_serial_ctrl dut (.MCLK_IN(mclk), .RSTN_IN(rstn), .FRAME_SEL_N_IN(sel_n),
        .SHIFT_CLK_IN(sclk), .SER_DATA_IN(din), .DAC_CODE_OUT(code), .MODE_OUT(mode),
        .ANALOG_CTL_OUT(actl), .LOAD_OUT(load));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift
    function automatic logic [5:0] exp_analog(input logic [1:0] m);
        case (m)
            2'h0: return 6'h27;
            2'h1: return 6'h10;
            2'h2: return 6'h08;
            default: return 6'h00;
        endcase
    endfunction : exp_analog
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic check_all();
        check("code", {4'h0, code}, {4'h0, exp_code});
        check("mode", {14'h0, mode}, {14'h0, exp_mode});
        check("analog", {10'h0, actl}, {10'h0, exp_analog(exp_mode)});
        check("loads", n_load[15:0], exp_load[15:0]);
    endtask : check_all
    // short frames abort; longer ones load only their first sixteen bits
    task automatic frame(input int n, input bit split, input bit park, input logic [1:0] m);
        logic [15:0] w;
        seed = xorshift(seed);
        w = {seed[15:14], m, seed[11:0]};
        host.send(w, n, split, park);
        repeat (8) @(posedge mclk);
        if (n >= 16) begin
            exp_code = w[11:0];
            exp_mode = w[13:12];
            exp_load++;
        end
        check_all();
        $display("test frame of %0d edges done", n);
    endtask : frame
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge mclk);
        #1 rstn = 1'b1;
        check_all();
        $display("test reset done");
        for (int m = 0; m < 4; m++) frame(16, 1'b0, 1'b0, m[1:0]);
        frame(15, 1'b0, 1'b0, 2'h1);
        frame(16, 1'b1, 1'b1, 2'h2);
        frame(20, 1'b0, 1'b1, 2'h0);
        frame(16, 1'b0, 1'b0, 2'h1);
        end_sim();
    end
endmodule : serial_dac_write_control_tb
`default_nettype wire
